//--- sto_coef_if.sv
// Purpose: Carrier between the register bank and the coefficient table
// Assumes: One clock, table read is combinational
// Notes: Bank drives address and write strobe, table returns entry
`timescale 1ns/1ps
interface sto_coef_if;
  logic [3:0] addr;
  logic [5:0] wdata;
  logic we;
  logic [5:0] rdata;

  modport bank
  (
    output addr,
    output wdata,
    output we,
    input rdata
  );

  modport lut
  (
    input addr,
    input wdata,
    input we,
    output rdata
  );
endinterface

//--- sto_coef_table.sv
// Purpose: Channel filter coefficient look-up table, 16 entries of 6 bits
// Assumes: Single clock, write strobe one cycle wide
// Notes: Entries reset to zero; read is combinational at the address
`timescale 1ns/1ps
module sto_coef_table
  import sto_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  sto_coef_if.lut coef
);

  logic [STO_COEF_DW-1:0] mem [STO_COEF_DEPTH];
  logic [STO_COEF_DW-1:0] next_mem [STO_COEF_DEPTH];

  always_comb
  begin
    for (int i = 0; i < STO_COEF_DEPTH; i++)
    begin
      next_mem[i] = mem[i];
    end
    if (coef.we)
    begin
      next_mem[coef.addr] = coef.wdata; // [RULE14]
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < STO_COEF_DEPTH; i++)
      begin
        mem[i] <= STO_COEF_VAL_RST;
      end
    end
    else
    begin
      mem <= next_mem;
    end
  end

  assign coef.rdata = mem[coef.addr]; // [RULE14]

endmodule // sto_coef_table

//--- sto_pkg.sv
// Purpose: Shared constants for the synthesizer test and override bank
// Assumes: Byte-wide register port, 8-bit addresses
// Notes: Offsets, reset values and named field positions live here; sto_regs slices the trim and test fields by literal bits
package sto_pkg;

  localparam int STO_AW = 8;
  localparam int STO_DW = 8;

  // Register offsets
  localparam logic [7:0] STO_DIV_TRIM_OFS = 8'h59;
  localparam logic [7:0] STO_VCO_TRIM_OFS = 8'h5a;
  localparam logic [7:0] STO_VCO_CAL_OFS = 8'h5b;
  localparam logic [7:0] STO_SYN_TEST_OFS = 8'h5c;
  localparam logic [7:0] STO_BLK_EN1_OFS = 8'h5d;
  localparam logic [7:0] STO_BLK_EN2_OFS = 8'h5e;
  localparam logic [7:0] STO_BLK_EN3_OFS = 8'h5f;
  localparam logic [7:0] STO_COEF_ADDR_OFS = 8'h60;
  localparam logic [7:0] STO_COEF_VAL_OFS = 8'h61;

  // Reset values
  localparam logic [7:0] STO_DIV_TRIM_RST = 8'h80;
  localparam logic [7:0] STO_VCO_TRIM_RST = 8'h00;
  localparam logic [7:0] STO_VCO_CAL_RST = 8'h00;
  localparam logic [7:0] STO_SYN_TEST_RST = 8'h0e;
  localparam logic [7:0] STO_BLK_EN_RST = 8'h00;
  localparam logic [7:0] STO_COEF_ADDR_RST = 8'h00;
  localparam logic [5:0] STO_COEF_VAL_RST = 6'h00;

  // Field positions
  localparam int STO_FBDIVHC_BIT = 6;
  localparam int STO_CORR_OV_BIT = 6;
  localparam int STO_CORR_HI = 5;
  localparam int STO_CORR_LO = 2;
  localparam int STO_CAL_OV_BIT = 7;
  localparam int STO_CAL_HI = 6;
  localparam int STO_DITHER_BIT = 7;
  localparam int STO_VCOTYPE_BIT = 6;
  localparam int STO_LDET_BIT = 6;
  localparam int STO_PLLRST_BIT = 0;
  localparam int STO_COEF_AW = 4;
  localparam int STO_COEF_DW = 6;
  localparam int STO_COEF_DEPTH = 16;

  // Block enable count and lock detect position in the enable vector
  localparam int STO_BLK_N = 24;
  localparam int STO_LDET_IDX = 8 + STO_LDET_BIT;

endpackage

//--- sto_regs.sv
// Purpose: Synthesizer and receive chain test and override register bank
// Assumes: Register port is the device's internal byte port behind the
//   serial interface; calibration engine sits outside this clock domain
// Notes: Reads answer one cycle after the read strobe
// Notes on behaviour
// RULE1: With the calibration override clear, reading the 7-bit calibration field gives the latest internal calibration result.
// RULE2: With the calibration override set, the written 7-bit calibration value is what the VCO receives.
// RULE3: Bit 7 of the calibration register reads 1 once calibration has finished and acts as the override bit on writes.
// RULE4: The dithering bit of the synthesizer test register turns modulator dithering off at 0 and allows it at 1.
// RULE5: The VCO type bit is read-only, 0 for a constant-gain VCO and 1 for a single-varactor VCO.
// RULE6: Bit 6 of the divider trim register enables the fractional divider high-current setting of +5 uA.
// RULE7: The divider trim register resets to 80h, reserved bit 7 at 1 and all other fields 0.
// RULE8: With bit 6 of the VCO trim register set, bits 5:2 drive the VCO current correction instead of the internal value.
// RULE9: The lock-detect enable bit drives the lock detector directly, with no override qualification.
// RULE10: Each bit of the three block-enable registers is an enable override value for one synthesizer or receive block.
// RULE11: Bit 0 of the second block-enable register is the override value for the PLL reset.
// RULE12: The 4-bit coefficient address selects the filter table entry reached through the coefficient value register.
// RULE13: With the global override enable high, overrides can enable and disable blocks; when low they can only enable.
// RULE14: The 6-bit coefficient value field reads and writes the table entry selected by the coefficient address.
// RULE15: Software writes reserved bits with their reset values and ignores them on read.
`timescale 1ns/1ps
module sto_regs
  import sto_pkg::*;
#(
  parameter logic STO_VCO_TYPE = 1'b0
)
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic vco_cal_done_i,
  input wire logic [6:0] vco_cal_result_i,
  input wire logic [3:0] vco_corr_int_i,
  input wire logic ovr_global_en_i,
  input wire logic [23:0] blk_en_int_i,
  output logic [6:0] vco_cal_o,
  output logic [3:0] vco_corr_o,
  output logic [1:0] vco_cur_trim_o,
  output logic fbdiv_hc_en_o,
  output logic [1:0] div3_trim_o,
  output logic [1:0] div2_trim_o,
  output logic [1:0] div1p5_trim_o,
  output logic dsm_dither_en_o,
  output logic [5:0] synth_test_o,
  output logic [23:0] blk_en_o,
  output logic lock_det_en_o,
  output logic pll_reset_o,
  output logic [5:0] coef_val_o
);

  sto_coef_if coef ();

  sto_coef_table u_table
  (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .coef(coef.lut)
  );

  // Stored register images
  logic [7:0] divider_current_trim;
  logic [7:0] vco_current_trim;
  logic cal_ovr;
  logic [6:0] cal_wr_val;
  logic [6:0] cal_result;
  logic [7:0] synth_test;
  logic [7:0] block_enable_override_1;
  logic [7:0] block_enable_override_2;
  logic [7:0] block_enable_override_3;
  logic [7:0] chan_filter_coef_address;
  logic [7:0] rdata;
  logic rvalid;

  logic [7:0] next_divider_current_trim;
  logic [7:0] next_vco_current_trim;
  logic next_cal_ovr;
  logic [6:0] next_cal_wr_val;
  logic [6:0] next_cal_result;
  logic [7:0] next_synth_test;
  logic [7:0] next_block_enable_override_1;
  logic [7:0] next_block_enable_override_2;
  logic [7:0] next_block_enable_override_3;
  logic [7:0] next_chan_filter_coef_address;
  logic [7:0] next_rdata;
  logic next_rvalid;

  // Calibration done synchroniser; level changes when stages 2 and 3 agree
  logic done_s1;
  logic done_s2;
  logic done_s3;
  logic cal_done;
  logic next_cal_done;

  logic [6:0] cal_applied;
  logic [23:0] ovr_bits;

  always_comb
  begin
    next_cal_done = cal_done;
    if (done_s2 == done_s3)
    begin
      next_cal_done = done_s3;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
      cal_done <= 1'b0;
    end
    else
    begin
      done_s1 <= vco_cal_done_i;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
      cal_done <= next_cal_done;
    end
  end

  // Override multiplexing toward the synthesizer
  assign cal_applied = cal_ovr ? cal_wr_val : cal_result; // [RULE2]
  assign ovr_bits = {block_enable_override_3,
                     block_enable_override_2,
                     block_enable_override_1};

  // Coefficient table access through the address pointer
  assign coef.addr = chan_filter_coef_address[STO_COEF_AW-1:0]; // [RULE12]
  assign coef.wdata = reg_wdata_i[STO_COEF_DW-1:0];
  assign coef.we = reg_we_i && (reg_addr_i == STO_COEF_VAL_OFS); // [RULE14]

  // Register writes, calibration capture and read mux
  always_comb
  begin
    next_divider_current_trim = divider_current_trim;
    next_vco_current_trim = vco_current_trim;
    next_cal_ovr = cal_ovr;
    next_cal_wr_val = cal_wr_val;
    next_cal_result = cal_result;
    next_synth_test = synth_test;
    next_block_enable_override_1 = block_enable_override_1;
    next_block_enable_override_2 = block_enable_override_2;
    next_block_enable_override_3 = block_enable_override_3;
    next_chan_filter_coef_address = chan_filter_coef_address;
    next_rdata = rdata;
    next_rvalid = reg_re_i;
    // Result bus is stable once done has settled high
    if (next_cal_done && !cal_done)
    begin
      next_cal_result = vco_cal_result_i; // [RULE1]
    end
    if (reg_we_i)
    begin
      unique case (reg_addr_i)
        STO_DIV_TRIM_OFS: next_divider_current_trim = reg_wdata_i;
        STO_VCO_TRIM_OFS: next_vco_current_trim = reg_wdata_i;
        STO_VCO_CAL_OFS:
        begin
          next_cal_ovr = reg_wdata_i[STO_CAL_OV_BIT]; // [RULE3]
          next_cal_wr_val = reg_wdata_i[STO_CAL_HI:0]; // [RULE2]
        end
        STO_SYN_TEST_OFS: next_synth_test = reg_wdata_i;
        STO_BLK_EN1_OFS: next_block_enable_override_1 = reg_wdata_i;
        STO_BLK_EN2_OFS: next_block_enable_override_2 = reg_wdata_i;
        STO_BLK_EN3_OFS: next_block_enable_override_3 = reg_wdata_i;
        STO_COEF_ADDR_OFS: next_chan_filter_coef_address = reg_wdata_i;
        default: next_rdata = rdata;
      endcase
    end
    if (reg_re_i)
    begin
      unique case (reg_addr_i)
        STO_DIV_TRIM_OFS: next_rdata = divider_current_trim;
        STO_VCO_TRIM_OFS: next_rdata = vco_current_trim;
        STO_VCO_CAL_OFS:
        begin
          next_rdata = {cal_done, // [RULE3]
                        cal_ovr ? cal_wr_val : cal_result}; // [RULE1]
        end
        STO_SYN_TEST_OFS:
        begin
          next_rdata = synth_test;
          next_rdata[STO_VCOTYPE_BIT] = STO_VCO_TYPE; // [RULE5]
        end
        STO_BLK_EN1_OFS: next_rdata = block_enable_override_1;
        STO_BLK_EN2_OFS: next_rdata = block_enable_override_2;
        STO_BLK_EN3_OFS: next_rdata = block_enable_override_3;
        STO_COEF_ADDR_OFS: next_rdata = chan_filter_coef_address;
        STO_COEF_VAL_OFS: next_rdata = {2'h0, coef.rdata}; // [RULE14]
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      divider_current_trim <= STO_DIV_TRIM_RST; // [RULE7]
      vco_current_trim <= STO_VCO_TRIM_RST;
      cal_ovr <= STO_VCO_CAL_RST[STO_CAL_OV_BIT];
      cal_wr_val <= STO_VCO_CAL_RST[STO_CAL_HI:0];
      cal_result <= STO_VCO_CAL_RST[STO_CAL_HI:0];
      synth_test <= STO_SYN_TEST_RST;
      block_enable_override_1 <= STO_BLK_EN_RST;
      block_enable_override_2 <= STO_BLK_EN_RST;
      block_enable_override_3 <= STO_BLK_EN_RST;
      chan_filter_coef_address <= STO_COEF_ADDR_RST;
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end
    else
    begin
      divider_current_trim <= next_divider_current_trim;
      vco_current_trim <= next_vco_current_trim;
      cal_ovr <= next_cal_ovr;
      cal_wr_val <= next_cal_wr_val;
      cal_result <= next_cal_result;
      synth_test <= next_synth_test;
      block_enable_override_1 <= next_block_enable_override_1;
      block_enable_override_2 <= next_block_enable_override_2;
      block_enable_override_3 <= next_block_enable_override_3;
      chan_filter_coef_address <= next_chan_filter_coef_address;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // Control outputs, all from flops of this bank
  logic [23:0] blk_en;
  logic [6:0] cal_out;
  logic [3:0] corr_out;
  logic [23:0] next_blk_en;
  logic [3:0] next_corr_out;

  always_comb
  begin
    for (int i = 0; i < STO_BLK_N; i++)
    begin
      // Global override lets a bit force off; otherwise it only forces on
      if (ovr_global_en_i)
      begin
        next_blk_en[i] = ovr_bits[i]; // [RULE13] [RULE10]
      end
      else
      begin
        next_blk_en[i] = blk_en_int_i[i] | ovr_bits[i]; // [RULE13]
      end
    end
    next_blk_en[STO_LDET_IDX] = ovr_bits[STO_LDET_IDX]; // [RULE9]
    if (vco_current_trim[STO_CORR_OV_BIT])
    begin
      next_corr_out = vco_current_trim[STO_CORR_HI:STO_CORR_LO]; // [RULE8]
    end
    else
    begin
      next_corr_out = vco_corr_int_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      blk_en <= 24'h000000;
      cal_out <= 7'h00;
      corr_out <= 4'h0;
    end
    else
    begin
      blk_en <= next_blk_en;
      cal_out <= cal_applied; // [RULE2]
      corr_out <= next_corr_out;
    end
  end

  assign reg_rdata_o = rdata;
  assign reg_rvalid_o = rvalid;
  assign vco_cal_o = cal_out;
  assign vco_corr_o = corr_out;
  assign vco_cur_trim_o = vco_current_trim[1:0];
  assign fbdiv_hc_en_o = divider_current_trim[STO_FBDIVHC_BIT]; // [RULE6]
  assign div3_trim_o = divider_current_trim[5:4];
  assign div2_trim_o = divider_current_trim[3:2];
  assign div1p5_trim_o = divider_current_trim[1:0];
  assign dsm_dither_en_o = synth_test[STO_DITHER_BIT]; // [RULE4]
  assign synth_test_o = synth_test[5:0];
  assign blk_en_o = blk_en;
  assign lock_det_en_o = blk_en[STO_LDET_IDX]; // [RULE9]
  assign pll_reset_o = blk_en[8 + STO_PLLRST_BIT]; // [RULE11]
  assign coef_val_o = coef.rdata;

endmodule // sto_regs

//--- sto_regs_asserts.sv
// Purpose: Port-level checks for the synthesizer test and override bank
// Assumes: Read answer one cycle after the read strobe, one clock
// Notes: Bound to every sto_regs instance below
`timescale 1ns/1ps
module sto_regs_asserts
  import sto_pkg::*;
#(
  parameter logic STO_VCO_TYPE = 1'b0
)
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic ovr_global_en_i,
  input wire logic [23:0] blk_en_int_i,
  input wire logic fbdiv_hc_en_o,
  input wire logic [1:0] div3_trim_o,
  input wire logic dsm_dither_en_o,
  input wire logic [5:0] synth_test_o,
  input wire logic [23:0] blk_en_o,
  input wire logic lock_det_en_o,
  input wire logic pll_reset_o,
  input wire logic [5:0] coef_val_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic mapped;
  logic wr_bk2;
  assign mapped = reg_addr_i >= STO_DIV_TRIM_OFS &&
    reg_addr_i <= STO_COEF_VAL_OFS;
  assign wr_bk2 = reg_we_i && reg_addr_i == STO_BLK_EN2_OFS;

  read_pulse_a: assert property (reg_rvalid_o == $past(reg_re_i))
    else $error("read valid not one cycle after strobe");
  unmapped_zero_a: assert property (
    reg_re_i && !mapped |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!reg_re_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  div_write_a: assert property (
    reg_we_i && reg_addr_i == STO_DIV_TRIM_OFS |=>
    {fbdiv_hc_en_o, div3_trim_o} == $past(reg_wdata_i[6:4]))
    else $error("divider trim outputs wrong after write");
  dither_write_a: assert property (
    reg_we_i && reg_addr_i == STO_SYN_TEST_OFS |=>
    dsm_dither_en_o == $past(reg_wdata_i[7]) &&
    synth_test_o == $past(reg_wdata_i[5:0]))
    else $error("dither or test outputs wrong after write");
  vco_type_a: assert property (
    reg_re_i && reg_addr_i == STO_SYN_TEST_OFS |=>
    reg_rdata_o[6] == STO_VCO_TYPE)
    else $error("vco type bit wrong");
  coef_read_a: assert property (
    reg_re_i && reg_addr_i == STO_COEF_VAL_OFS |=>
    reg_rdata_o == {2'b00, $past(coef_val_o)})
    else $error("coefficient read wrong");
  ldet_tie_a: assert property (
    lock_det_en_o == blk_en_o[14] && pll_reset_o == blk_en_o[8])
    else $error("lock detect or pll reset not tied to enables");
  ldet_write_a: assert property (
    wr_bk2 ##1 !wr_bk2 |=> lock_det_en_o == $past(reg_wdata_i[6], 2))
    else $error("lock detect not direct from register");
  enable_only_a: assert property (
    !ovr_global_en_i |=>
    (($past(blk_en_int_i) & ~blk_en_o) & 24'hffbfff) == 24'h000000)
    else $error("internal enable lost with global override low");

  cover property (reg_we_i && reg_addr_i == STO_VCO_CAL_OFS &&
    reg_wdata_i[7]);
  cover property (reg_re_i && reg_addr_i == STO_COEF_VAL_OFS);
  cover property (ovr_global_en_i && reg_we_i && reg_addr_i ==
    STO_BLK_EN1_OFS);
endmodule // sto_regs_asserts

bind sto_regs sto_regs_asserts #(.STO_VCO_TYPE(STO_VCO_TYPE)) u_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .ovr_global_en_i(ovr_global_en_i), .blk_en_int_i(blk_en_int_i),
  .fbdiv_hc_en_o(fbdiv_hc_en_o), .div3_trim_o(div3_trim_o),
  .dsm_dither_en_o(dsm_dither_en_o), .synth_test_o(synth_test_o),
  .blk_en_o(blk_en_o), .lock_det_en_o(lock_det_en_o),
  .pll_reset_o(pll_reset_o), .coef_val_o(coef_val_o));

//--- tb_sto.sv
// Purpose: Self-checking bench for the synthesizer test and override bank
// Assumes: Inputs driven at the falling edge, reads answer next cycle
// Notes: Register image and coefficient table modelled in the bench
`timescale 1ns/1ps
module tb;
  import sto_pkg::*;
  localparam logic VT = 1'b1;
  logic clk_sys_i, rst_i, reg_we_i, reg_re_i, reg_rvalid_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic vco_cal_done_i, ovr_global_en_i, fbdiv_hc_en_o, dsm_dither_en_o;
  logic lock_det_en_o, pll_reset_o;
  logic [6:0] vco_cal_result_i, vco_cal_o;
  logic [3:0] vco_corr_int_i, vco_corr_o;
  logic [1:0] vco_cur_trim_o, div3_trim_o, div2_trim_o, div1p5_trim_o;
  logic [5:0] synth_test_o, coef_val_o;
  logic [23:0] blk_en_int_i, blk_en_o, ovr, eb;
  logic [7:0] m [8'h59:8'h60];
  logic [5:0] coef [16];
  logic cal_done_m;
  logic [6:0] cal_cap;
  int errors, n_tests, cyc;

  sto_regs #(.STO_VCO_TYPE(VT)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .vco_cal_done_i(vco_cal_done_i), .vco_cal_result_i(vco_cal_result_i),
    .vco_corr_int_i(vco_corr_int_i), .ovr_global_en_i(ovr_global_en_i),
    .blk_en_int_i(blk_en_int_i), .vco_cal_o(vco_cal_o),
    .vco_corr_o(vco_corr_o), .vco_cur_trim_o(vco_cur_trim_o),
    .fbdiv_hc_en_o(fbdiv_hc_en_o), .div3_trim_o(div3_trim_o),
    .div2_trim_o(div2_trim_o), .div1p5_trim_o(div1p5_trim_o),
    .dsm_dither_en_o(dsm_dither_en_o), .synth_test_o(synth_test_o),
    .blk_en_o(blk_en_o), .lock_det_en_o(lock_det_en_o),
    .pll_reset_o(pll_reset_o), .coef_val_o(coef_val_o));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [23:0] e,
    input logic [23:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    logic [6:0] c;
    c = m[8'h5b][7] ? m[8'h5b][6:0] : cal_cap;
    case (a)
      STO_VCO_CAL_OFS: return {cal_done_m, c};
      STO_SYN_TEST_OFS: return {m[a][7], VT, m[a][5:0]};
      STO_COEF_VAL_OFS: return {2'b00, coef[m[8'h60][3:0]]};
      default: return (a >= 8'h59 && a <= 8'h60) ? m[a] : 8'h00;
    endcase
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_we_i = 1'b1;
    @(negedge clk_sys_i);
    reg_we_i = 1'b0;
    @(negedge clk_sys_i);
    if (a >= 8'h59 && a <= 8'h60)
      m[a] = d;
    if (a == STO_COEF_VAL_OFS)
      coef[m[8'h60][3:0]] = d[5:0];
  endtask

  task automatic rd(input logic [7:0] a);
    reg_addr_i = a;
    reg_re_i = 1'b1;
    @(negedge clk_sys_i);
    reg_re_i = 1'b0;
    chk("rvalid", 24'h000001, 24'(reg_rvalid_o));
    chk("rdata", 24'(exp_rd(a)), 24'(reg_rdata_o));
    // Let an edge pass so a following read raises its strobe afresh
    @(negedge clk_sys_i);
  endtask

  task automatic outs;
    @(negedge clk_sys_i);
    ovr = {m[8'h5f], m[8'h5e], m[8'h5d]};
    eb = ovr_global_en_i ? ovr : (ovr | blk_en_int_i);
    eb[14] = ovr[14];
    chk("div", 24'(m[8'h59][6:0]), 24'({fbdiv_hc_en_o, div3_trim_o,
      div2_trim_o, div1p5_trim_o}));
    chk("cur", 24'(m[8'h5a][1:0]), 24'(vco_cur_trim_o));
    chk("corr", 24'(m[8'h5a][6] ? m[8'h5a][5:2] : vco_corr_int_i),
      24'(vco_corr_o));
    chk("cal", 24'(exp_rd(8'h5b) & 8'h7f), 24'(vco_cal_o));
    chk("test", 24'({m[8'h5c][7], m[8'h5c][5:0]}),
      24'({dsm_dither_en_o, synth_test_o}));
    chk("blk", eb, blk_en_o);
    chk("pll", 24'(eb[8]), 24'(pll_reset_o));
    chk("ldet", 24'(ovr[14]), 24'(lock_det_en_o));
    chk("coef", 24'(coef[m[8'h60][3:0]]), 24'(coef_val_o));
  endtask

  initial
  begin
    rst_i = 1'b1;
    {reg_we_i, reg_re_i, vco_cal_done_i, ovr_global_en_i} = 4'h0;
    {reg_addr_i, reg_wdata_i, vco_cal_result_i, vco_corr_int_i} = '0;
    blk_en_int_i = 24'h000000;
    void'($urandom(32'hb3458105));
    for (int a = 8'h59; a <= 8'h60; a++)
      m[a] = 8'h00;
    m[8'h59] = STO_DIV_TRIM_RST;
    m[8'h5c] = STO_SYN_TEST_RST;
    foreach (coef[i])
      coef[i] = 6'h00;
    cal_done_m = 1'b0;
    cal_cap = 7'h00;
    repeat (4) @(negedge clk_sys_i);
    rst_i = 1'b0;
    for (int a = 8'h57; a <= 8'h62; a++)
      rd(8'(a));
    outs();
    for (int r = 0; r < 6; r++)
    begin
      ovr_global_en_i = r[0];
      blk_en_int_i = 24'($urandom);
      vco_corr_int_i = 4'($urandom);
      for (int a = 8'h59; a <= 8'h60; a++)
        wr(8'(a), 8'($urandom));
      outs();
      for (int a = 8'h59; a <= 8'h61; a++)
        rd(8'(a));
    end
    for (int i = 0; i < 16; i++)
    begin
      wr(STO_COEF_ADDR_OFS, {4'($urandom), 4'(i)});
      wr(STO_COEF_VAL_OFS, 8'($urandom));
    end
    for (int i = 15; i >= 0; i--)
    begin
      wr(STO_COEF_ADDR_OFS, 8'(i));
      rd(STO_COEF_VAL_OFS);
      outs();
    end
    wr(STO_VCO_CAL_OFS, 8'h00);
    vco_cal_result_i = 7'($urandom);
    vco_cal_done_i = 1'b1;
    repeat (10) @(negedge clk_sys_i);
    cal_done_m = 1'b1;
    cal_cap = vco_cal_result_i;
    vco_cal_result_i = ~vco_cal_result_i;
    rd(STO_VCO_CAL_OFS);
    outs();
    wr(STO_VCO_CAL_OFS, {1'b1, 7'($urandom)});
    rd(STO_VCO_CAL_OFS);
    outs();
    wr(STO_VCO_CAL_OFS, 8'h00);
    rd(STO_VCO_CAL_OFS);
    outs();
    close_out();
  end
endmodule // tb
